// ### hw/tlic_top.sv
// Two-level interrupt controller with APB register access
//
// Summary of operation
// - Enable bit 7 globally gates acknowledgement; when set, per-source enables apply.
// - Enable bit 5 gates timer 2, bit 4 gates the serial port.
// - Enable bit 3 gates timer 1, bit 2 gates external 1.
// - Enable bit 1 gates timer 0, bit 0 gates external 0.
// - Each source has a priority bit; one selects the high level.
// - Priority bits 5, 4, 3 belong to timer 2, serial, timer 1.
// - Priority bits 2, 1, 0 belong to external 1, timer 0, external 0.
// - Priority bit 7 set stops the level logic; only enables then apply.
// - High requests preempt a low service; low requests never do.
// - A running high service is never preempted.
// - Simultaneous requests of both levels: the high one goes first.
// - Within a level a fixed polling order picks the winner.
// - All source flags are latched during state 5 of each machine cycle.
// - Samples are polled next cycle; a winner gets a long call to its vector.
// - Requests are blocked while an equal or higher level is in progress.
// - The long call pushes the program counter and jumps to the vector; the core model here only acknowledges the call.
// - An interrupt return clears the in-progress flag of the level served.
// - Six sources: two external, three timers, one serial port.
// - An interrupt return with nothing in progress acts as a plain return.
// - A machine cycle is six states of two clocks, twelve clocks in all.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module tlic_top
    import tlic_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         srst_i,
    input  wire logic         ce_i,
    // APB slave
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [7:0]   paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    // Source flags from peripherals on this clock
    input  wire logic [5:0]   src_flag_i,
    // CPU side
    input  wire logic         call_ack_i,
    input  wire logic         interrupt_return_i,
    output logic              long_call_o,
    output logic      [2:0]   call_vector_o,
    output logic              call_level_o,
    output logic      [1:0]   in_progress_o,
    output logic      [2:0]   mc_state_o
);

    // Software registers and block state
    logic [7:0]  enable_ff;
    logic [7:0]  priority_ff;
    logic [3:0]  phase_cnt_ff;
    logic [5:0]  sample_ff;
    logic [1:0]  inprog_ff;
    logic        call_req_ff;
    logic [2:0]  call_vec_ff;
    logic        call_lvl_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [2:0]  mc_state_ff;

    // Polling decode
    logic [5:0]  eligible;
    logic [5:0]  high_map;
    logic [5:0]  high_req;
    logic [5:0]  low_req;
    logic        nxt_take;
    logic [2:0]  nxt_vec;
    logic        nxt_lvl;
    logic [1:0]  nxt_inprog;
    logic        poll_slot;
    logic        bus_done;
    logic        addr_hit;
    logic [31:0] rd_mux;

    // Index of the first set bit, lowest index first
    function automatic logic [2:0] first_set(input logic [5:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Machine cycle sequencer, twelve clocks per cycle
    // six two-clock states
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            phase_cnt_ff <= 4'h0;
        end
        else if (ce_i)
        begin
            phase_cnt_ff <= (phase_cnt_ff == LAST_CNT) ? 4'h0 : phase_cnt_ff + 4'h1;
        end
    end

    // State number 1..6 shown to the core for its own timing
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            mc_state_ff <= 3'h1;
        end
        else if (ce_i)
        begin
            mc_state_ff <= (phase_cnt_ff == LAST_CNT) ? 3'h1
                         : 3'((phase_cnt_ff + 4'h1) / 4'(CLK_PER_STATE) + 4'h1);
        end
    end

    // six sources, the third timer always present here
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            sample_ff <= 6'h00;
        end
        else if (ce_i && phase_cnt_ff == LATCH_CNT)
        begin
            sample_ff <= src_flag_i;
        end
    end

    // Enable gating; bit 6 never reaches the logic
    // global gate
    // timer 1 and external 1 gates
    // timer 0 and external 0 gates
    assign eligible = sample_ff & enable_ff[5:0] & {6{enable_ff[GLOBAL_ENABLE_BIT]}};

    // Level map; a stopped level circuit puts every source on the low level
    // one selects high
    assign high_map = priority_ff[PRIORITY_STOP_BIT] ? 6'h00 : priority_ff[5:0];
    assign high_req = eligible & high_map;
    assign low_req  = eligible & ~high_map;

    // Arbitration; level first, then bit order within a level
    // high level first
    always_comb
    begin
        nxt_take = 1'b0;
        nxt_vec  = 3'h0;
        nxt_lvl  = 1'b0;
        if (high_req != 6'h00 && !inprog_ff[LVL_HIGH])
        begin
            nxt_take = 1'b1;
            nxt_vec  = first_set(high_req);
            nxt_lvl  = 1'b1;
        end
        else if (low_req != 6'h00 && inprog_ff == 2'b00)
        begin
            nxt_take = 1'b1;
            nxt_vec  = first_set(low_req);
            nxt_lvl  = 1'b0;
        end
    end

    // Polling waits while a call is still unacknowledged
    assign poll_slot = ce_i && phase_cnt_ff == POLL_CNT && !call_req_ff;

    // Long call request held until the core takes it
    // poll next cycle, call vector
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            call_req_ff <= 1'b0;
            call_vec_ff <= 3'h0;
            call_lvl_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (call_req_ff && call_ack_i)
            begin
                call_req_ff <= 1'b0;
            end
            else if (poll_slot && nxt_take)
            begin
                call_req_ff <= 1'b1;
                call_vec_ff <= nxt_vec;
                call_lvl_ff <= nxt_lvl;
            end
        end
    end

    // In-progress flags; the acknowledge set wins over a return clear
    // return clears served level
    always_comb
    begin
        nxt_inprog = inprog_ff;
        if (interrupt_return_i)
        begin
            if (inprog_ff[LVL_HIGH])
            begin
                nxt_inprog[LVL_HIGH] = 1'b0;
            end
            else
            begin
                nxt_inprog[LVL_LOW] = 1'b0;
            end
        end
        if (call_req_ff && call_ack_i)
        begin
            nxt_inprog[call_lvl_ff] = 1'b1;
        end
    end

    // Level flags advance only while the clock enable runs
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            inprog_ff <= 2'b00;
        end
        else if (ce_i)
        begin
            inprog_ff <= nxt_inprog;
        end
    end

    // APB decode; one wait state, then answer
    assign bus_done = psel_i && penable_i && pready_ff;
    assign addr_hit = paddr_i == ENABLE_OFS || paddr_i == PRIORITY_OFS
                   || paddr_i == STATUS_OFS;

    // Read mux; upper bits read as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            ENABLE_OFS:   rd_mux = {24'h00_0000, enable_ff};
            PRIORITY_OFS: rd_mux = {24'h00_0000, priority_ff};
            STATUS_OFS:   rd_mux = {24'h00_0000, 1'b0, call_lvl_ff, inprog_ff,
                                    call_req_ff, call_vec_ff};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // Access phase answer, registered so outputs come from flops
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            if (psel_i && penable_i && !pready_ff)
            begin
                pready_ff  <= 1'b1;
                pslverr_ff <= !addr_hit;
                prdata_ff  <= pwrite_i ? 32'h0000_0000 : rd_mux;
            end
            else
            begin
                pready_ff  <= 1'b0;
                pslverr_ff <= 1'b0;
            end
        end
    end

    // Register writes land at the completing edge only
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            enable_ff   <= ENABLE_RST;
            priority_ff <= PRIORITY_RST;
        end
        else if (ce_i && bus_done && pwrite_i)
        begin
            if (paddr_i == ENABLE_OFS)
            begin
                enable_ff <= pwdata_i[7:0];
            end
            if (paddr_i == PRIORITY_OFS)
            begin
                priority_ff <= pwdata_i[7:0];
            end
        end
    end

    // Outputs straight from flops
    assign prdata_o      = prdata_ff;
    assign pready_o      = pready_ff;
    assign pslverr_o     = pslverr_ff;
    assign long_call_o   = call_req_ff;
    assign call_vector_o = call_vec_ff;
    assign call_level_o  = call_lvl_ff;
    assign in_progress_o = inprog_ff;
    assign mc_state_o    = mc_state_ff;

    // Checks on the arbitration and sequencing
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    a_global_gate: assert property ($rose(call_req_ff) |-> $past(enable_ff[7]))
        else $error("call raised with global enable clear");

    a_source_enabled: assert property ($rose(call_req_ff) |-> $past(eligible[nxt_vec]))
        else $error("call raised for a disabled source");

    a_level_match: assert property ($rose(call_req_ff) |->
            call_lvl_ff == $past(high_map[nxt_vec]))
        else $error("call level disagrees with priority map");

    a_stop_flat: assert property ($rose(call_req_ff) && $past(priority_ff[7]) |->
            !call_lvl_ff)
        else $error("high level used while level logic stopped");

    a_high_no_nest: assert property ($rose(call_req_ff) |-> !$past(inprog_ff[1]))
        else $error("call raised during a high service");

    a_low_no_nest: assert property ($rose(call_req_ff) && !call_lvl_ff |->
            !$past(inprog_ff[0]))
        else $error("low call raised during a low service");

    a_poll_slot: assert property ($rose(call_req_ff) |-> $past(phase_cnt_ff) == POLL_CNT)
        else $error("call raised outside the poll slot");

    a_poll_order: assert property ($rose(call_req_ff) |->
            ((call_lvl_ff ? $past(high_req) : $past(low_req))
            & ((6'h01 << call_vec_ff) - 6'h01)) == 6'h00)
        else $error("polling order violated");

    a_return_clear: assert property (ce_i && interrupt_return_i && inprog_ff[1]
            && !(call_req_ff && call_ack_i) |=> !inprog_ff[1])
        else $error("return left high level in progress");

    a_cycle_wrap: assert property (ce_i && phase_cnt_ff == LAST_CNT |=>
            phase_cnt_ff == 4'h0)
        else $error("machine cycle not twelve clocks");

    c_high_call: cover property ($rose(call_req_ff) && call_lvl_ff);
    c_low_call:  cover property ($rose(call_req_ff) && !call_lvl_ff);
    c_preempt:   cover property ($rose(call_req_ff) && call_lvl_ff && inprog_ff[0]);
    c_bus_err:   cover property (pready_ff && pslverr_ff);

endmodule

// ### hw/tlic_pkg.sv
// Shared constants for the two-level interrupt controller
package tlic_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] ENABLE_OFS   = 8'h00;
    localparam logic [7:0] PRIORITY_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;

    // Reset values of the software registers
    localparam logic [7:0] ENABLE_RST   = 8'h00;
    localparam logic [7:0] PRIORITY_RST = 8'h00;

    // Enable register field positions
    localparam int GLOBAL_ENABLE_BIT   = 7;
    localparam int TIMER2_ENABLE_BIT   = 5;
    localparam int SERIAL_ENABLE_BIT   = 4;
    localparam int TIMER1_ENABLE_BIT   = 3;
    localparam int EXTERNAL1_ENABLE_BIT = 2;
    localparam int TIMER0_ENABLE_BIT   = 1;
    localparam int EXTERNAL0_ENABLE_BIT = 0;

    // Priority register field positions
    localparam int PRIORITY_STOP_BIT   = 7;
    localparam int TIMER2_LEVEL_BIT    = 5;
    localparam int SERIAL_LEVEL_BIT    = 4;
    localparam int TIMER1_LEVEL_BIT    = 3;
    localparam int EXTERNAL1_LEVEL_BIT = 2;
    localparam int TIMER0_LEVEL_BIT    = 1;
    localparam int EXTERNAL0_LEVEL_BIT = 0;

    // Source count; source index equals its enable and level bit
    localparam int NUM_SRC = 6;

    // Machine cycle timing
    localparam int MC_STATES     = 6;
    localparam int CLK_PER_STATE = 2;
    localparam int MC_CLKS       = MC_STATES * CLK_PER_STATE;
    localparam logic [3:0] LAST_CNT   = 4'(MC_CLKS - 1);
    // Last clock of state 5 latches the flags
    localparam logic [3:0] LATCH_CNT  = 4'(5 * CLK_PER_STATE - 1);
    // Last clock of state 1 of the following cycle polls the samples
    localparam logic [3:0] POLL_CNT   = 4'(1 * CLK_PER_STATE - 1);

    // In-progress level indices
    localparam int LVL_LOW  = 0;
    localparam int LVL_HIGH = 1;

endpackage

// ### sim/tlic_cpu_model.sv
// Behavioural CPU core that takes long calls and issues interrupt returns
`timescale 1ns/100ps
module tlic_cpu_model
(
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       long_call_i,
    input  wire logic [3:0] ack_dly_i,
    input  wire logic       ret_req_i,
    output logic            call_ack_o,
    output logic            interrupt_return_o
);
    logic [3:0] wait_ff;

    // wait ack_dly_i clocks, then acknowledge
    // Slow answers model a core still finishing an instruction
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || !long_call_i || call_ack_o)
        begin
            wait_ff    <= 4'h0;
            call_ack_o <= 1'b0;
        end
        else if (wait_ff == ack_dly_i)
            call_ack_o <= 1'b1;
        else
            wait_ff <= wait_ff + 4'h1;
    end

    always_ff @(posedge mclk_i)
    begin
        interrupt_return_o <= ret_req_i && !srst_i;
    end
endmodule

// ### sim/two_level_interrupt_controller_test.sv
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/100ps
module two_level_interrupt_controller_test
    import tlic_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [5:0]  src_flag = 6'h00;
    logic        ret_req = 1'b0;
    logic [3:0]  ack_dly = 4'h0;
    logic        ce = 1'b1;
    logic [2:0]  mc_state;
    logic [31:0] prdata;
    logic        pready, pslverr, call_ack, int_ret, long_call, call_lvl;
    logic [2:0]  call_vec;
    logic [1:0]  in_prog;
    int          err_total = 0;
    int          check_count = 0;

    // Free-running clock, 40 ns period
    initial
    begin
        forever #20 clk = ~clk;
    end

    tlic_top dut_u
    (
        .mclk_i(clk), .srst_i(srst), .ce_i(ce), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .src_flag_i(src_flag),
        .call_ack_i(call_ack), .interrupt_return_i(int_ret), .long_call_o(long_call),
        .call_vector_o(call_vec), .call_level_o(call_lvl), .in_progress_o(in_prog),
        .mc_state_o(mc_state)
    );

    tlic_cpu_model cpu_u
    (
        .mclk_i(clk), .srst_i(srst), .long_call_i(long_call), .ack_dly_i(ack_dly),
        .ret_req_i(ret_req), .call_ack_o(call_ack), .interrupt_return_o(int_ret)
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // One APB transfer; held until pready is sampled high
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so a following call never drives psel twice in one step
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
        chk("write err", {31'h0, exp_err}, {31'h0, e});
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp,
                       input logic exp_err);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(what, exp, rd);
        chk("read err", {31'h0, exp_err}, {31'h0, e});
    endtask

    // Flags drop for a full machine cycle first, so no stale sample meets new enables
    task automatic cfg(input logic [7:0] en, input logic [7:0] pri, input logic [5:0] fl);
        src_flag <= 6'h00;
        repeat (MC_CLKS) @(posedge clk);
        wr(ENABLE_OFS, {24'h0, en}, 1'b0);
        wr(PRIORITY_OFS, {24'h0, pri}, 1'b0);
        src_flag <= fl;
    endtask

    // Waits for a call, drops the flags, then checks the acknowledged level
    task automatic expect_call(input logic [2:0] vec, input logic lvl, input logic [1:0] ip);
        int n;
        n = 0;
        while (long_call !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        src_flag <= 6'h00;
        chk("call", 32'h1, {31'h0, long_call});
        chk("vector", {29'h0, vec}, {29'h0, call_vec});
        chk("level", {31'h0, lvl}, {31'h0, call_lvl});
        while (long_call === 1'b1 && n < 80)
        begin
            @(posedge clk);
            n++;
        end
        chk("in progress", {30'h0, ip}, {30'h0, in_prog});
    endtask

    task automatic expect_none();
        logic seen;
        seen = 1'b0;
        repeat (30)
        begin
            @(posedge clk);
            seen |= (long_call === 1'b1);
        end
        chk("no call", 32'h0, {31'h0, seen});
    endtask

    task automatic do_ret(input logic [1:0] ip);
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        repeat (2) @(posedge clk);
        chk("after return", {30'h0, ip}, {30'h0, in_prog});
    endtask

    task automatic serve(input logic [2:0] vec, input logic lvl);
        expect_call(vec, lvl, lvl ? 2'b10 : 2'b01);
        do_ret(2'b00);
    endtask

    task automatic t_regs();
        rdc("enable", ENABLE_OFS, 32'h0, 1'b0);
        rdc("priority", PRIORITY_OFS, 32'h0, 1'b0);
        rdc("status", STATUS_OFS, 32'h0, 1'b0);
        wr(ENABLE_OFS, 32'hFFFFFFFF, 1'b0);
        rdc("enable rw", ENABLE_OFS, 32'hFF, 1'b0);
        wr(PRIORITY_OFS, 32'hFFFFFFFF, 1'b0);
        rdc("priority rw", PRIORITY_OFS, 32'hFF, 1'b0);
        wr(8'h0C, 32'hFF, 1'b1);
        rdc("unmapped", 8'h0C, 32'h0, 1'b1);
        $display("test regs done");
    endtask

    // Each enable alone admits its source; clearing it shuts the source out
    task automatic t_gate();
        cfg(8'h7F, 8'h00, 6'h3F);
        expect_none();
        for (int i = 0; i < 6; i++)
        begin
            cfg(8'h80 | (8'h01 << i), 8'h00, 6'h3F);
            serve(i[2:0], 1'b0);
            cfg(8'hBF & ~(8'h01 << i), 8'h00, 6'h01 << i);
            expect_none();
        end
        $display("test gate done");
    endtask

    task automatic t_order();
        for (int i = 0; i < 6; i++)
        begin
            cfg(8'hFF, 8'h40, 6'h3F << i);
            serve(i[2:0], 1'b0);
        end
        $display("test order done");
    endtask

    task automatic t_level();
        for (int i = 0; i < 6; i++)
        begin
            cfg(8'hBF, 8'h01 << i, 6'h3F);
            serve(i[2:0], 1'b1);
        end
        cfg(8'hBF, 8'hA0, 6'h3F);
        serve(3'h0, 1'b0);
        $display("test level done");
    endtask

    // Nesting with a slow core: low, then high on top, then unwinding
    task automatic t_nest();
        ack_dly <= 4'h6;
        cfg(8'hBF, 8'h02, 6'h01);
        expect_call(3'h0, 1'b0, 2'b01);
        src_flag <= 6'h04;
        expect_none();
        src_flag <= 6'h06;
        expect_call(3'h1, 1'b1, 2'b11);
        src_flag <= 6'h07;
        expect_none();
        src_flag <= 6'h05;
        expect_none();
        do_ret(2'b01);
        expect_none();
        do_ret(2'b00);
        expect_call(3'h0, 1'b0, 2'b01);
        do_ret(2'b00);
        do_ret(2'b00);
        $display("test nest done");
    endtask

    // Clock enable low: no latch, no poll, state frozen; running again, the call follows
    task automatic t_freeze();
        logic [2:0] st;
        cfg(8'h81, 8'h00, 6'h01);
        ce <= 1'b0;
        @(posedge clk);
        st = mc_state;
        expect_none();
        chk("state frozen", {29'h0, st}, {29'h0, mc_state});
        ce <= 1'b1;
        serve(3'h0, 1'b0);
        $display("test freeze done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run of under two thousand cycles
    initial
    begin
        repeat (30000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_gate();
        t_order();
        t_level();
        t_freeze();
        t_nest();
        give_verdict();
    end
endmodule
